// ==== common/memsys_regs_pkg.sv ====
/*
  Shared constants for the memory-subsystem status and access register slice:
  register byte offsets, field positions, reset values and interrupt bit layout.
  Assumes a 32-bit APB register bus with one aligned word per register.
*/
package memsys_regs_pkg;
  // register byte offsets
  localparam logic [11:0] OFS_DMA_ERR_ADDR = 12'h000;
  localparam logic [11:0] OFS_AHB_ERR_ADDR = 12'h004;
  localparam logic [11:0] OFS_BUF_EMPTY = 12'h008;
  localparam logic [11:0] OFS_BUF_OFF_DONE = 12'h00c;
  localparam logic [11:0] OFS_SRAM0_CNT = 12'h010;
  localparam logic [11:0] OFS_SRAM1_CNT = 12'h014;
  localparam logic [11:0] OFS_SRAM0_LOC = 12'h018;
  localparam logic [11:0] OFS_SRAM1_LOC = 12'h01c;
  localparam logic [11:0] OFS_PERM_M45F = 12'h020;
  localparam logic [11:0] OFS_PERM_M37 = 12'h024;
  localparam logic [11:0] OFS_PERM_M9 = 12'h028;
  localparam logic [11:0] OFS_IRQ_STATUS = 12'h02c;
  localparam logic [11:0] OFS_IRQ_ENABLE = 12'h030;
  localparam logic [11:0] OFS_IRQ_CLEAR = 12'h034;
  // field positions
  localparam int TAG_W = 28;
  localparam int CNT_W = 16;
  localparam int LOC_W = 13;
  localparam int LOC_DBL_LSB = 13;
  localparam int NUM_SLAVES = 5;
  localparam int PERM_W = 2 * NUM_SLAVES;
  localparam int BUF_DMA_RD = 5;
  localparam int BUF_DMA_WR = 4;
  localparam int BUF_AHB_RD = 3;
  localparam int BUF_AHB_WR = 2;
  // reset values
  localparam logic [PERM_W-1:0] PERM_RESET = 10'h3ff;
  // interrupt status bits
  localparam int IRQ_W = 6;
  localparam int IRQ_DMA_FLUSH = 0;
  localparam int IRQ_AHB_FLUSH = 1;
  localparam int IRQ_SRAM0_SGL = 2;
  localparam int IRQ_SRAM0_DBL = 3;
  localparam int IRQ_SRAM1_SGL = 4;
  localparam int IRQ_SRAM1_DBL = 5;
endpackage

// ==== core/memsys_status_and_access_regs.sv ====
/*
  Memory-subsystem status and access register slice: flush error address capture,
  bridge buffer empty and disable-done status, saturating ECC counters and
  locations for two SRAM banks, and per-master slave permission checks.
  Assumes event inputs are single-cycle pulses in the CLK domain from the bridge
  and SRAM logic, and an APB master on the same clock.
*/
// Design decisions made here: the address map and the APB slave port.
`timescale 1ns/1ps
// What this block does
// [RQ1] DMA flush error response loads its tag-derived address into DMA error register.
// [RQ2] DMA address: 16-byte tag in 31:4; 32-byte tag 27:1 in 31:5; low bits zero.
// [RQ3] AHB flush error response loads its tag-derived address into AHB error register.
// [RQ4] AHB error address uses the same packing as the DMA one.
// [RQ5] Empty status bit 5 is DMA read buffer, bit 4 DMA write buffer.
// [RQ6] Empty status bit 3 is AHB read buffer, bit 2 AHB write buffer.
// [RQ7] DMA read/write disable done sets bit 5 or bit 4 once disabled.
// [RQ8] AHB read/write disable done sets bit 3 or bit 2 once disabled.
// [RQ9] SRAM bank 0 counts double errors in 31:16, single in 15:0.
// [RQ10] Each ECC counter saturates at all ones and never wraps.
// [RQ11] SRAM bank 1 keeps the same pair of saturating counters.
// [RQ12] SRAM bank 0 stores double error address 25:13, single 12:0.
// [RQ13] SRAM bank 1 stores double error address 25:13, single 12:0.
// [RQ14] Permission bits: odd write-allow, even read-allow, slaves 0,1,2,3,6 in 9:0.
// [RQ15] Masters 4, 5 and fabric port blocked per their permission register.
// [RQ16] Masters 3 and 7 blocked per their shared permission register.
// [RQ17] Master 9 blocked per its own permission register.
// [RQ18] Each new error event overwrites the previously captured address.
// [RQ19] Status registers read-only, writes ignored; permission registers read-write.
module memsys_status_and_access_regs
  import memsys_regs_pkg::*;
#(
  parameter int ADDR_W = 12 // apb address width
) (
  input wire logic CLK, // system clock, 50 MHz
  input wire logic RST_B, // synchronous reset, active low
  input wire logic PSEL, // apb select
  input wire logic PENABLE, // apb access phase
  input wire logic PWRITE, // apb direction, high for write
  input wire logic [ADDR_W-1:0] PADDR, // apb byte address
  input wire logic [31:0] PWDATA, // apb write data
  output logic [31:0] PRDATA, // apb read data
  output logic PREADY, // apb ready
  output logic PSLVERR, // apb error on unmapped address
  input wire logic DMA_FLUSH_ERR, // pulse: dma write buffer flush got error response
  input wire logic DMA_BUF_32B, // dma buffer is 32 bytes, else 16
  input wire logic [TAG_W-1:0] DMA_FLUSH_TAG, // tag of failing dma flush
  input wire logic AHB_FLUSH_ERR, // pulse: ahb write buffer flush got error response
  input wire logic AHB_BUF_32B, // ahb buffer is 32 bytes, else 16
  input wire logic [TAG_W-1:0] AHB_FLUSH_TAG, // tag of failing ahb flush
  input wire logic [3:0] BUF_EMPTY, // level: dma rd, dma wr, ahb rd, ahb wr empty
  input wire logic [3:0] BUF_OFF_DONE, // level: same order, buffer disabled
  input wire logic [1:0] SRAM_SGL_ERR, // pulse per bank: single-bit error
  input wire logic [1:0] SRAM_DBL_ERR, // pulse per bank: double-bit error
  input wire logic [LOC_W-1:0] SRAM0_ERR_ADDR, // bank 0 failing address
  input wire logic [LOC_W-1:0] SRAM1_ERR_ADDR, // bank 1 failing address
  input wire logic [2:0] ACC_GROUP, // requesting master: 0 m4/m5/fabric, 1 m3/m7, 2 m9
  input wire logic [2:0] ACC_SLAVE, // target slave number 0,1,2,3 or 6
  input wire logic ACC_WRITE, // request direction, high for write
  output logic ACC_ALLOW, // registered: request is allowed
  output logic IRQ // level interrupt
);

  // permission bits of each group reach the grant logic directly
  logic [PERM_W-1:0] perm_m45f;
  logic [PERM_W-1:0] perm_m37;
  logic [PERM_W-1:0] perm_m9;
  logic [31:0] dma_err_addr_field;
  logic [31:0] ahb_err_addr_field;
  logic [3:0] buf_empty_q;
  logic [3:0] buf_off_q;
  logic [CNT_W-1:0] sram0_single_err_count;
  logic [CNT_W-1:0] sram0_double_err_count;
  logic [CNT_W-1:0] sram1_single_err_count;
  logic [CNT_W-1:0] sram1_double_err_count;
  logic [LOC_W-1:0] sram0_single_err_addr;
  logic [LOC_W-1:0] sram0_double_err_addr;
  logic [LOC_W-1:0] sram1_single_err_addr;
  logic [LOC_W-1:0] sram1_double_err_addr;
  logic [IRQ_W-1:0] irq_status;
  logic [IRQ_W-1:0] irq_enable;

  // apb decode: single-cycle access, ready high in every access phase
  wire access = PSEL & PENABLE;
  wire wr = access & PWRITE;
  wire rd = access & ~PWRITE;
  wire [11:0] ofs = 12'(PADDR);
  wire wr_m45f = wr & (ofs == OFS_PERM_M45F);
  wire wr_m37 = wr & (ofs == OFS_PERM_M37);
  wire wr_m9 = wr & (ofs == OFS_PERM_M9);
  wire wr_irq_en = wr & (ofs == OFS_IRQ_ENABLE);
  wire wr_irq_clr = wr & (ofs == OFS_IRQ_CLEAR);

  // tag packing shared by both flush error captures
  function automatic logic [31:0] pack_tag(input logic [TAG_W-1:0] tag, input logic is32);
    pack_tag = is32 ? {tag[TAG_W-1:1], 5'h00} : {tag, 4'h0}; // RQ2 RQ4
  endfunction

  function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] c);
    sat_inc = (&c) ? c : c + 16'h0001; // RQ10
  endfunction

  wire [31:0] next_dma_addr = pack_tag(DMA_FLUSH_TAG, DMA_BUF_32B); // RQ2
  wire [31:0] next_ahb_addr = pack_tag(AHB_FLUSH_TAG, AHB_BUF_32B); // RQ4

  // external status levels come from another domain, two flops before use
  logic [3:0] empty_s1;
  logic [3:0] off_s1;
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      empty_s1 <= 4'h0;
      buf_empty_q <= 4'h0;
    end else begin
      empty_s1 <= BUF_EMPTY;
      buf_empty_q <= empty_s1; // RQ5 RQ6
    end
  end

  // disable-done levels; a done pulse shorter than one cycle may be missed
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      off_s1 <= 4'h0;
      buf_off_q <= 4'h0;
    end else begin
      off_s1 <= BUF_OFF_DONE;
      buf_off_q <= off_s1; // RQ7 RQ8
    end
  end

  // dma flush error address capture; newest event overwrites
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      dma_err_addr_field <= 32'h0;
    end else begin
      if (DMA_FLUSH_ERR) dma_err_addr_field <= next_dma_addr; // RQ1 RQ18
    end
  end

  // ahb flush error address capture; newest event overwrites
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      ahb_err_addr_field <= 32'h0;
    end else begin
      if (AHB_FLUSH_ERR) ahb_err_addr_field <= next_ahb_addr; // RQ3 RQ18
    end
  end

  // sram bank 0 single-bit count, one step per high cycle
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      sram0_single_err_count <= 16'h0;
    end else begin
      if (SRAM_SGL_ERR[0]) sram0_single_err_count <= sat_inc(sram0_single_err_count); // RQ9 RQ10
    end
  end

  // sram bank 0 double-bit count
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      sram0_double_err_count <= 16'h0;
    end else begin
      if (SRAM_DBL_ERR[0]) sram0_double_err_count <= sat_inc(sram0_double_err_count); // RQ9 RQ10
    end
  end

  // sram bank 0 single-bit location, newest wins
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      sram0_single_err_addr <= 13'h0;
    end else begin
      if (SRAM_SGL_ERR[0]) sram0_single_err_addr <= SRAM0_ERR_ADDR; // RQ12 RQ18
    end
  end

  // sram bank 0 double-bit location, newest wins
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      sram0_double_err_addr <= 13'h0;
    end else begin
      if (SRAM_DBL_ERR[0]) sram0_double_err_addr <= SRAM0_ERR_ADDR; // RQ12 RQ18
    end
  end

  // sram bank 1 single-bit count, one step per high cycle
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      sram1_single_err_count <= 16'h0;
    end else begin
      if (SRAM_SGL_ERR[1]) sram1_single_err_count <= sat_inc(sram1_single_err_count); // RQ11 RQ10
    end
  end

  // sram bank 1 double-bit count
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      sram1_double_err_count <= 16'h0;
    end else begin
      if (SRAM_DBL_ERR[1]) sram1_double_err_count <= sat_inc(sram1_double_err_count); // RQ11 RQ10
    end
  end

  // sram bank 1 single-bit location, newest wins
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      sram1_single_err_addr <= 13'h0;
    end else begin
      if (SRAM_SGL_ERR[1]) sram1_single_err_addr <= SRAM1_ERR_ADDR; // RQ13 RQ18
    end
  end

  // sram bank 1 double-bit location, newest wins
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      sram1_double_err_addr <= 13'h0;
    end else begin
      if (SRAM_DBL_ERR[1]) sram1_double_err_addr <= SRAM1_ERR_ADDR; // RQ13 RQ18
    end
  end

  // permission registers, software-writable like the interrupt enable and clear registers
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      perm_m45f <= PERM_RESET;
    end else begin
      if (wr_m45f) perm_m45f <= PWDATA[PERM_W-1:0]; // RQ19
    end
  end

  // masters 3 and 7 share one permission word
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      perm_m37 <= PERM_RESET;
    end else begin
      if (wr_m37) perm_m37 <= PWDATA[PERM_W-1:0]; // RQ19
    end
  end

  // master 9 permission word
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      perm_m9 <= PERM_RESET;
    end else begin
      if (wr_m9) perm_m9 <= PWDATA[PERM_W-1:0]; // RQ19
    end
  end

  // interrupt events; a new event wins over a clear in the same cycle
  wire [IRQ_W-1:0] irq_events = {SRAM_DBL_ERR[1], SRAM_SGL_ERR[1], SRAM_DBL_ERR[0],
                                 SRAM_SGL_ERR[0], AHB_FLUSH_ERR, DMA_FLUSH_ERR};
  wire [IRQ_W-1:0] irq_clr = wr_irq_clr ? PWDATA[IRQ_W-1:0] : '0;
  wire [IRQ_W-1:0] next_irq_status = (irq_status & ~irq_clr) | irq_events;
  wire [IRQ_W-1:0] next_irq_enable = wr_irq_en ? PWDATA[IRQ_W-1:0] : irq_enable;

  // sticky status bits
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      irq_status <= '0;
    end else begin
      irq_status <= next_irq_status;
    end
  end

  // interrupt enable mask
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      irq_enable <= '0;
    end else begin
      irq_enable <= next_irq_enable;
    end
  end

  // output from next values so the pin moves in step with the status it reflects
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= |(next_irq_status & next_irq_enable);
    end
  end

  // slave number to permission pair index; slave 6 sits in the top pair
  wire slave_ok = (ACC_SLAVE <= 3'd3) | (ACC_SLAVE == 3'd6);
  wire [2:0] pair = (ACC_SLAVE == 3'd6) ? 3'd4 : ACC_SLAVE;
  wire [PERM_W-1:0] grp_perm = (ACC_GROUP == 3'd0) ? perm_m45f : // RQ15
                               (ACC_GROUP == 3'd1) ? perm_m37 : // RQ16
                               (ACC_GROUP == 3'd2) ? perm_m9 : '0; // RQ17
  wire [3:0] bit_idx = {pair, ACC_WRITE}; // RQ14
  wire next_allow = slave_ok & grp_perm[bit_idx];

  // read select lines; reserved bits read zero, unmapped offsets flag an error
  wire sel_dma = (ofs == OFS_DMA_ERR_ADDR);
  wire sel_ahb = (ofs == OFS_AHB_ERR_ADDR);
  wire sel_empty = (ofs == OFS_BUF_EMPTY);
  wire sel_off = (ofs == OFS_BUF_OFF_DONE);
  wire sel_cnt0 = (ofs == OFS_SRAM0_CNT);
  wire sel_cnt1 = (ofs == OFS_SRAM1_CNT);
  wire sel_loc0 = (ofs == OFS_SRAM0_LOC);
  wire sel_loc1 = (ofs == OFS_SRAM1_LOC);
  wire sel_m45f = (ofs == OFS_PERM_M45F);
  wire sel_m37 = (ofs == OFS_PERM_M37);
  wire sel_m9 = (ofs == OFS_PERM_M9);
  wire sel_stat = (ofs == OFS_IRQ_STATUS);
  wire sel_en = (ofs == OFS_IRQ_ENABLE);
  wire sel_clr = (ofs == OFS_IRQ_CLEAR);
  wire rd_hit = sel_dma | sel_ahb | sel_empty | sel_off | sel_cnt0 | sel_cnt1 | sel_loc0 | sel_loc1 |
                sel_m45f | sel_m37 | sel_m9 | sel_stat | sel_en | sel_clr;
  // and-or read mux; the clear register reads zero, so it has no term
  wire [31:0] rd_mux = ({32{sel_dma}} & dma_err_addr_field) |
                       ({32{sel_ahb}} & ahb_err_addr_field) |
                       ({32{sel_empty}} & {26'h0, buf_empty_q, 2'h0}) |
                       ({32{sel_off}} & {26'h0, buf_off_q, 2'h0}) |
                       ({32{sel_cnt0}} & {sram0_double_err_count, sram0_single_err_count}) |
                       ({32{sel_cnt1}} & {sram1_double_err_count, sram1_single_err_count}) |
                       ({32{sel_loc0}} & {6'h0, sram0_double_err_addr, sram0_single_err_addr}) |
                       ({32{sel_loc1}} & {6'h0, sram1_double_err_addr, sram1_single_err_addr}) |
                       ({32{sel_m45f}} & {22'h0, perm_m45f}) |
                       ({32{sel_m37}} & {22'h0, perm_m37}) |
                       ({32{sel_m9}} & {22'h0, perm_m9}) |
                       ({32{sel_stat}} & {26'h0, irq_status}) |
                       ({32{sel_en}} & {26'h0, irq_enable});

  // writes to read-only offsets are ignored without error
  wire next_ready = PSEL & ~PENABLE;

  // ready answers in the first access cycle, so no wait states
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      PREADY <= 1'b0;
    end else begin
      PREADY <= next_ready;
    end
  end

  // error pulse stands beside ready for unmapped offsets
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      PSLVERR <= 1'b0;
    end else begin
      PSLVERR <= next_ready & ~rd_hit;
    end
  end

  // read data stands only with ready, zero otherwise
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      PRDATA <= 32'h0;
    end else begin
      PRDATA <= (next_ready & ~PWRITE) ? rd_mux : 32'h0;
    end
  end

  // access verdict, one cycle behind the request inputs
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      ACC_ALLOW <= 1'b0;
    end else begin
      ACC_ALLOW <= next_allow; // RQ15 RQ16 RQ17
    end
  end

endmodule

// ==== testbench/memsys_regs_asserts.sv ====
/*
  Concurrent checks on the register slice ports: apb timing, reserved read bits, access denials.
  Assumes one clock domain and the synchronous active-low reset of the slice.
*/
`timescale 1ns/1ps
module memsys_regs_asserts
  import memsys_regs_pkg::*;
#(
  parameter int ADDR_W = 12 // apb address width
) (
  input wire logic CLK, // system clock
  input wire logic RST_B, // synchronous reset, active low
  input wire logic PSEL, // apb select
  input wire logic PENABLE, // apb access phase
  input wire logic PWRITE, // apb direction
  input wire logic [ADDR_W-1:0] PADDR, // apb address
  input wire logic [31:0] PRDATA, // apb read data
  input wire logic PREADY, // apb ready
  input wire logic PSLVERR, // apb error
  input wire logic [2:0] ACC_GROUP, // requesting master group
  input wire logic [2:0] ACC_SLAVE, // target slave
  input wire logic ACC_ALLOW // access verdict
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_B);
  // a completed read; other cycles must show zero data
  wire rd_done = PREADY && !PWRITE;
  wire rd_buf = rd_done && (PADDR == OFS_BUF_EMPTY || PADDR == OFS_BUF_OFF_DONE);
  wire rd_loc = rd_done && (PADDR == OFS_SRAM0_LOC || PADDR == OFS_SRAM1_LOC);

  AST_READY_SETUP: assert property (PSEL && !PENABLE |=> PREADY)
    else $error("no ready one cycle after setup");
  AST_READY_PULSE: assert property (PREADY |=> !PREADY)
    else $error("ready held longer than one cycle");
  AST_ERR_READY: assert property (PSLVERR |-> PREADY && PRDATA == 32'h0)
    else $error("error without ready or with data");
  AST_IDLE_DATA: assert property (!rd_done |-> PRDATA == 32'h0)
    else $error("read data outside a read");
  AST_BUF_RSVD: assert property (rd_buf |-> PRDATA[31:6] == 26'h0 && PRDATA[1:0] == 2'h0)
    else $error("reserved buffer status bit set");
  AST_LOC_RSVD: assert property (rd_loc |-> PRDATA[31:26] == 6'h0)
    else $error("reserved location bit set");
  AST_GROUP_DENY: assert property (ACC_GROUP > 3'h2 |=> !ACC_ALLOW)
    else $error("unknown master group allowed");
  AST_SLAVE_DENY: assert property (ACC_SLAVE inside {3'h4, 3'h5, 3'h7} |=> !ACC_ALLOW)
    else $error("unmapped slave allowed");
  COV_ERR: cover property (PSLVERR);
  COV_ALLOW: cover property (ACC_ALLOW);
  COV_CNT: cover property (rd_done && PADDR == OFS_SRAM1_CNT);
endmodule
bind memsys_status_and_access_regs memsys_regs_asserts #(.ADDR_W(ADDR_W)) i_asserts (
  .CLK(CLK), .RST_B(RST_B), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
  .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .ACC_GROUP(ACC_GROUP),
  .ACC_SLAVE(ACC_SLAVE), .ACC_ALLOW(ACC_ALLOW));

// ==== testbench/memsys_fabric_model.sv ====
/*
  Behavioural bridge and sram event source facing the register slice.
  Assumes the bench calls its tasks; all changes land just after a rising edge.
*/
`timescale 1ns/1ps
module memsys_fabric_model
  import memsys_regs_pkg::*;
(
  input wire logic clk, // system clock
  output logic dma_err, // dma flush error pulse
  output logic dma_32b, // dma buffer is 32 bytes
  output logic [TAG_W-1:0] dma_tag, // dma flush tag
  output logic ahb_err, // ahb flush error pulse
  output logic ahb_32b, // ahb buffer is 32 bytes
  output logic [TAG_W-1:0] ahb_tag, // ahb flush tag
  output logic [3:0] empty, // buffer empty levels
  output logic [3:0] off_done, // buffer disabled levels
  output logic [1:0] sgl, // single error pulses
  output logic [1:0] dbl, // double error pulses
  output logic [LOC_W-1:0] addr0, // bank 0 error address
  output logic [LOC_W-1:0] addr1 // bank 1 error address
);
  initial begin
    {dma_err, dma_32b, dma_tag, ahb_err, ahb_32b, ahb_tag} = '0;
    {empty, off_done, sgl, dbl, addr0, addr1} = '0;
  end
  // one flush error response; tags scrambled afterwards so a stale tag is never captured
  task automatic flush(input logic ahb, input logic b32, input logic [TAG_W-1:0] tag);
    @(posedge clk);
    dma_err <= !ahb;
    ahb_err <= ahb;
    {dma_32b, ahb_32b} <= {b32, b32};
    {dma_tag, ahb_tag} <= {tag, tag};
    @(posedge clk);
    {dma_err, ahb_err} <= 2'b00;
    {dma_tag, ahb_tag} <= {~tag, ~tag};
  endtask
  // n consecutive ecc error cycles on one bank
  task automatic ecc(input int bank, input logic two, input logic [LOC_W-1:0] a, input int n);
    @(posedge clk);
    sgl[bank] <= !two;
    dbl[bank] <= two;
    {addr0, addr1} <= {a, a};
    repeat (n) @(posedge clk);
    {sgl, dbl} <= 4'h0;
    {addr0, addr1} <= {~a, ~a};
  endtask
  // buffer levels; a disable command completes two cycles later
  task automatic set_empty(input logic [3:0] v);
    @(posedge clk);
    empty <= v;
  endtask
  task automatic buf_off(input logic [3:0] v);
    repeat (2) @(posedge clk);
    off_done <= v;
  endtask
endmodule

// ==== testbench/memsys_status_and_access_regs_tb_top.sv ====
/*
  Self-checking bench for the memory-subsystem register slice over apb.
  Assumes the event model in memsys_fabric_model and a 50 MHz clock.
*/
`timescale 1ns/1ps
module memsys_status_and_access_regs_tb_top;
  import memsys_regs_pkg::*;
  logic clk, rst_b, psel, penable, pwrite, acc_write, err;
  logic dma_err, dma_32b, ahb_err, ahb_32b, pready, pslverr, acc_allow, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [TAG_W-1:0] dma_tag, ahb_tag;
  logic [3:0] empty, off_done;
  logic [1:0] sgl, dbl;
  logic [LOC_W-1:0] addr0, addr1;
  logic [2:0] acc_group, acc_slave;
  logic [9:0] perm [3];
  int failures, check_count, cycles;

  memsys_status_and_access_regs #(.ADDR_W(12)) i_dut (
    .CLK(clk), .RST_B(rst_b), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .DMA_FLUSH_ERR(dma_err),
    .DMA_BUF_32B(dma_32b), .DMA_FLUSH_TAG(dma_tag), .AHB_FLUSH_ERR(ahb_err), .AHB_BUF_32B(ahb_32b),
    .AHB_FLUSH_TAG(ahb_tag), .BUF_EMPTY(empty), .BUF_OFF_DONE(off_done), .SRAM_SGL_ERR(sgl),
    .SRAM_DBL_ERR(dbl), .SRAM0_ERR_ADDR(addr0), .SRAM1_ERR_ADDR(addr1), .ACC_GROUP(acc_group),
    .ACC_SLAVE(acc_slave), .ACC_WRITE(acc_write), .ACC_ALLOW(acc_allow), .IRQ(irq));
  memsys_fabric_model i_src (
    .clk(clk), .dma_err(dma_err), .dma_32b(dma_32b), .dma_tag(dma_tag), .ahb_err(ahb_err),
    .ahb_32b(ahb_32b), .ahb_tag(ahb_tag), .empty(empty), .off_done(off_done), .sgl(sgl),
    .dbl(dbl), .addr0(addr0), .addr1(addr1));

  // clock and hang guard; the saturation run dominates the cycle budget
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 90000) begin
      failures++;
      end_of_test();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  // apb transfer: setup, access until ready, then release
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  // access request held two edges, verdict sampled once registered
  task automatic acc(input int g, input int s, input logic w, input logic exp);
    @(posedge clk);
    {acc_group, acc_slave, acc_write} <= {3'(g), 3'(s), w};
    repeat (2) @(posedge clk);
    chk({31'h0, acc_allow}, {31'h0, exp});
  endtask
  task automatic end_of_test();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  initial begin
    {rst_b, psel, penable, pwrite, paddr, pwdata, acc_group, acc_slave, acc_write} = '0;
    {failures, check_count, cycles} = '0;
    perm = '{10'h155, 10'h2aa, 10'h0f3};
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    // status registers start at zero and ignore writes
    for (int i = 0; i < 8; i++) begin
      rdc(12'(4 * i), 32'h0);
      apb(1'b1, 12'(4 * i), 32'hffffffff);
      rdc(12'(4 * i), 32'h0);
    end
    rdc(OFS_PERM_M9, 32'h3ff);
    apb(1'b0, 12'h038, 32'h0);
    chk({31'h0, err}, 32'h1);
    // flush captures: 16-byte dma, 32-byte ahb, then a dma overwrite
    i_src.flush(1'b0, 1'b0, 28'h1234567);
    rdc(OFS_DMA_ERR_ADDR, 32'h12345670);
    i_src.flush(1'b1, 1'b1, 28'habcdef1);
    rdc(OFS_AHB_ERR_ADDR, 32'habcdef00);
    i_src.flush(1'b0, 1'b1, 28'h0000013);
    rdc(OFS_DMA_ERR_ADDR, 32'h00000120);
    // every buffer status bit on its own
    for (int i = 0; i < 4; i++) begin
      i_src.set_empty(4'(1 << i));
      i_src.buf_off(4'(1 << i));
      repeat (4) @(posedge clk);
      rdc(OFS_BUF_EMPTY, 32'h4 << i);
      rdc(OFS_BUF_OFF_DONE, 32'h4 << i);
    end
    // ecc counts, latest addresses, and saturation of a single-error counter
    i_src.ecc(0, 1'b0, 13'h00a5, 2);
    i_src.ecc(0, 1'b0, 13'h1f0e, 1);
    i_src.ecc(0, 1'b1, 13'h1abc, 1);
    rdc(OFS_SRAM0_CNT, 32'h00010003);
    rdc(OFS_SRAM0_LOC, {6'h0, 13'h1abc, 13'h1f0e});
    i_src.ecc(1, 1'b1, 13'h0777, 2);
    i_src.ecc(1, 1'b0, 13'h1555, 65537);
    rdc(OFS_SRAM1_CNT, 32'h0002ffff);
    rdc(OFS_SRAM1_LOC, {6'h0, 13'h0777, 13'h1555});
    // a distinct pattern per master group, every slave both ways
    for (int g = 0; g < 3; g++) apb(1'b1, OFS_PERM_M45F + 12'(4 * g), {22'h0, perm[g]});
    for (int g = 0; g < 3; g++) rdc(OFS_PERM_M45F + 12'(4 * g), {22'h0, perm[g]});
    for (int g = 0; g < 3; g++)
      for (int p = 0; p < 5; p++)
        for (int w = 0; w < 2; w++) acc(g, p == 4 ? 6 : p, w[0], perm[g][2 * p + w]);
    acc(3, 0, 1'b0, 1'b0);
    acc(0, 5, 1'b0, 1'b0);
    // interrupt: masked event, enabled event, then clear
    apb(1'b1, OFS_IRQ_CLEAR, 32'h3f);
    apb(1'b1, OFS_IRQ_ENABLE, 32'h1 << IRQ_AHB_FLUSH);
    i_src.flush(1'b0, 1'b0, 28'h1);
    @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    i_src.flush(1'b1, 1'b0, 28'h2);
    @(posedge clk);
    chk({31'h0, irq}, 32'h1);
    rdc(OFS_IRQ_STATUS, 32'h3);
    apb(1'b1, OFS_IRQ_CLEAR, 32'h1 << IRQ_AHB_FLUSH);
    @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    rdc(OFS_IRQ_STATUS, 32'h1);
    rdc(OFS_IRQ_CLEAR, 32'h0);
    end_of_test();
  end
endmodule
